// ---- shared/wakeup_strap_map.svh ----
// Constants for the host wake-up strap decoder: field positions, widths,
// reset values and timing counts.
// Assumes inclusion by bare name from design files.
`ifndef WAKEUP_STRAP_MAP_SVH
`define WAKEUP_STRAP_MAP_SVH

`define WK_VALUE_W       16
`define WK_ADDR_W        20
`define WK_SEG_SHIFT     4
`define WK_PAGE_W        4
`define WK_PORT8_W       8
`define WK_INT_LINES     8
`define WK_INT_SEL_W     3
`define WK_PAGE_LOW      4'h0
`define WK_PAGE_HIGH     4'hF
`define WK_VALUE_RST     16'h0000
`define WK_INT_IDLE      8'hFF
// Settle time after reset before straps are taken, in ns
`define WK_SETTLE_NS     20
`define WK_CLK_NS        5
`define WK_SETTLE_CYC    ((`WK_SETTLE_NS + `WK_CLK_NS - 1) / `WK_CLK_NS)

`endif

// ---- shared/wakeup_strap_pkg.sv ----
// Types for the host wake-up strap decoder.
// Assumes the constants header is compiled alongside.
package wakeup_strap_pkg;

	typedef enum logic [1:0] {
		ST_RESET  = 2'b00,
		ST_SETTLE = 2'b01,
		ST_RUN    = 2'b10
	} phase_e;

	typedef logic [15:0] wakeValue_t;

endpackage

// ---- verilog/strap_sampler.sv ----
// Two-stage synchroniser and capture register for the strap inputs.
// Assumes straps are quasi-static board levels from outside the clock domain.
`timescale 1ns/1ps
`include "wakeup_strap_map.svh"

module strap_sampler #(
	parameter int W = 8
) (
	input  wire logic         sys_clk,
	input  wire logic         arst_n,
	input  wire logic         capture,
	input  wire logic [W-1:0] pins,
	output logic      [W-1:0] held
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
		logic [W-1:0] held;
	} state_s;

	state_s state_q;
	state_s state_d;

	always_comb begin
		state_d = state_q;
		state_d.meta = pins;
		state_d.sync = state_q.meta;
		if (capture) begin
			state_d.held = state_q.sync;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign held = state_q.held;
endmodule

// ---- verilog/host_wakeup_strap_decoder.sv ----
// Decodes board straps that set up the link to the host: wake-up memory
// address, wake-up I/O port match, data width and interrupt line steering.
// Assumes straps are static board levels; host bus cycles arrive as
// synchronous requests on sys_clk.
// Functional notes
// R01: Sixteen wake-up straps read 1 if fitted, 0 if absent, as bits 15 to 0.
// R02: The value is a zero-offset segment shifted left by four into 20 bits.
// R03: Top four bits of 24-bit addresses are 0 without page strap, F with it.
// R04: Port number is bits 0-7 of value in 8-bit mode, 0-15 in 16-bit mode.
// R05: Port width strap fitted selects 16-bit port decoding, absent 8-bit.
// R06: Bus width strap fitted selects a 16-bit data path, absent an 8-bit one.
// R07: With 16-bit width, memory transfers are 16-bit where memory allows it.
// R08: Interrupt request drives one of eight active-low lines, set by strap.
// R09: Host keeps four blocks; device reads the first at the wake-up address.
// R10: Host signals via the wake-up port; matching accesses are recognised.
// R11: All straps are sampled after reset and held constant during operation.
`timescale 1ns/1ps
`include "wakeup_strap_map.svh"

module host_wakeup_strap_decoder (
	input  wire logic        sys_clk,
	input  wire logic        arst_n,
	input  wire logic [7:0]  wakeupHighByteStraps,
	input  wire logic [9:0]  wakeupLowByteAndWidthStraps,
	input  wire logic        topPageSelectStrap,
	input  wire logic [2:0]  interruptLineSelectStrap,
	input  wire logic        intRequest,
	input  wire logic        memWideCapable,
	input  wire logic        ioAccess,
	input  wire logic [15:0] ioPortAddr,
	output logic             strapsValid,
	output logic [19:0]      wakeupAddr,
	output logic [23:0]      wakeupAddr24,
	output logic [15:0]      wakeupPort,
	output logic             portWide,
	output logic             busWide,
	output logic             memXferWide,
	output logic             wakeupHit,
	output logic [7:0]       intLine_n
);
	// Low straps: [7:0] value bits 7..0, [8] port width, [9] bus width
	localparam int NSTRAP = 8 + 10 + 1 + 3;

	typedef struct packed {
		wakeup_strap_pkg::phase_e     phase;
		logic [2:0]                   settle;
		logic                         valid;
		logic [19:0]                  addr;
		logic [23:0]                  addr24;
		logic [15:0]                  port;
		logic                         portWide;
		logic                         busWide;
		logic                         memWide;
		logic                         hit;
		logic [7:0]                   intLine;
	} state_s;

	state_s state_q;
	state_s state_d;

	logic                       capture;
	logic [NSTRAP-1:0]          strapPins;
	logic [NSTRAP-1:0]          strapHeld;
	wakeup_strap_pkg::wakeValue_t wakeValue;
	logic                       heldPortWide;
	logic                       heldBusWide;
	logic                       heldPage;
	logic [2:0]                 heldIntSel;

	// Port number under the chosen decode width
	function automatic logic [15:0] portOf(input logic [15:0] v,
					       input logic wide);
		portOf = wide ? v : {8'h00, v[7:0]}; // [R04]
	endfunction

	assign strapPins = {interruptLineSelectStrap, topPageSelectStrap,
			    wakeupLowByteAndWidthStraps, wakeupHighByteStraps};

	// Straps are pins, so they pass two flops before the capture register
	strap_sampler #(.W(NSTRAP)) u_sampler (
		.sys_clk (sys_clk),
		.arst_n  (arst_n),
		.capture (capture),
		.pins    (strapPins),
		.held    (strapHeld)
	);

	// Fitted strap is a one, absent a zero; high byte holds bits 15..8
	assign wakeValue    = {strapHeld[7:0], strapHeld[15:8]}; // [R01]
	assign heldPortWide = strapHeld[16];
	assign heldBusWide  = strapHeld[17];
	assign heldPage     = strapHeld[18];
	assign heldIntSel   = strapHeld[21:19];

	// Capture once the synchroniser has filled after reset, then freeze
	assign capture = (state_q.phase == wakeup_strap_pkg::ST_SETTLE) &&
			 (state_q.settle == 3'(`WK_SETTLE_CYC)); // [R11]

	always_comb begin
		state_d = state_q;
		unique case (state_q.phase)
			wakeup_strap_pkg::ST_RESET: begin
				state_d.phase = wakeup_strap_pkg::ST_SETTLE;
				state_d.settle = 3'h0;
			end
			wakeup_strap_pkg::ST_SETTLE: begin
				state_d.settle = state_q.settle + 3'h1;
				if (capture) begin
					state_d.phase = wakeup_strap_pkg::ST_RUN;
				end
			end
			wakeup_strap_pkg::ST_RUN: begin
				state_d.valid = 1'b1;
			end
			default: begin
				state_d.phase = wakeup_strap_pkg::ST_RESET;
			end
		endcase

		// Derived fields settle one cycle after capture and never move
		if (state_q.phase == wakeup_strap_pkg::ST_RUN) begin
			state_d.addr = {wakeValue, 4'h0}; // [R02] [R09]
			state_d.addr24 = {heldPage ? `WK_PAGE_HIGH : `WK_PAGE_LOW,
					  wakeValue, 4'h0}; // [R03]
			state_d.port = portOf(wakeValue, heldPortWide); // [R04]
			state_d.portWide = heldPortWide; // [R05]
			state_d.busWide = heldBusWide; // [R06]
		end

		// Wide memory transfers only with the bus width strap fitted and the memory capable
		state_d.memWide = state_q.valid && state_q.busWide &&
				  memWideCapable; // [R07]

		// Upper port bits are ignored in 8-bit decode
		state_d.hit = state_q.valid && ioAccess &&
			      (portOf(ioPortAddr, state_q.portWide) ==
			       state_q.port); // [R10]

		// Exactly one line low while requesting once straps are valid, all high otherwise
		state_d.intLine = `WK_INT_IDLE;
		if (state_q.valid && intRequest) begin
			state_d.intLine = ~(8'h01 << heldIntSel); // [R08]
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= '{phase: wakeup_strap_pkg::ST_RESET,
				     intLine: `WK_INT_IDLE, default: '0};
		end else begin
			state_q <= state_d;
		end
	end

	assign strapsValid  = state_q.valid;
	assign wakeupAddr   = state_q.addr;
	assign wakeupAddr24 = state_q.addr24;
	assign wakeupPort   = state_q.port;
	assign portWide     = state_q.portWide;
	assign busWide      = state_q.busWide;
	assign memXferWide  = state_q.memWide;
	assign wakeupHit    = state_q.hit;
	assign intLine_n    = state_q.intLine;

	property p_int_onehot;
		@(posedge sys_clk) disable iff (!arst_n)
		strapsValid |-> $countones(~intLine_n) <= 1;
	endproperty
	a_int_onehot: assert property (p_int_onehot) // [R08]
		else $error("more than one interrupt line low");

	property p_int_follow;
		@(posedge sys_clk) disable iff (!arst_n)
		(strapsValid && intRequest) |=>
			intLine_n == ~(8'h01 << heldIntSel);
	endproperty
	a_int_follow: assert property (p_int_follow) // [R08]
		else $error("interrupt not on selected line");

	property p_addr_shift;
		@(posedge sys_clk) disable iff (!arst_n)
		strapsValid |-> wakeupAddr == {wakeValue, 4'h0};
	endproperty
	a_addr_shift: assert property (p_addr_shift) // [R02]
		else $error("wake-up address not value shifted by four");

	property p_page;
		@(posedge sys_clk) disable iff (!arst_n)
		strapsValid |-> wakeupAddr24[23:20] == {4{heldPage}};
	endproperty
	a_page: assert property (p_page) // [R03]
		else $error("top page bits wrong");

	property p_port8;
		@(posedge sys_clk) disable iff (!arst_n)
		(strapsValid && !portWide) |-> wakeupPort[15:8] == 8'h00;
	endproperty
	a_port8: assert property (p_port8) // [R04]
		else $error("narrow port has upper bits");

	property p_hit;
		@(posedge sys_clk) disable iff (!arst_n)
		(strapsValid && ioAccess && portWide &&
		 ioPortAddr == wakeupPort) |=> wakeupHit;
	endproperty
	a_hit: assert property (p_hit) // [R10]
		else $error("matching port access missed");

	property p_nohit;
		@(posedge sys_clk) disable iff (!arst_n)
		!ioAccess |=> !wakeupHit;
	endproperty
	a_nohit: assert property (p_nohit) // [R10]
		else $error("hit without access");

	property p_frozen;
		@(posedge sys_clk) disable iff (!arst_n)
		$past(strapsValid) && strapsValid |->
			$stable(wakeupPort) && $stable(busWide);
	endproperty
	a_frozen: assert property (p_frozen) // [R11]
		else $error("strap decode changed in operation");

	property p_memwide;
		@(posedge sys_clk) disable iff (!arst_n)
		(strapsValid && !busWide) |=> !memXferWide;
	endproperty
	a_memwide: assert property (p_memwide) // [R06] [R07]
		else $error("wide transfer on narrow bus");

	property p_valid_time;
		@(posedge sys_clk) disable iff (!arst_n)
		$rose(arst_n) |-> ##[1:8] strapsValid;
	endproperty
	a_valid_time: assert property (p_valid_time) // [R11]
		else $error("straps not valid in time");

	property p_valid_stays;
		@(posedge sys_clk) disable iff (!arst_n)
		strapsValid |=> strapsValid;
	endproperty
	a_valid_stays: assert property (p_valid_stays) // [R11]
		else $error("strap capture lost in operation");

	// Requests before capture must not reach the backplane
	property p_refuse_int;
		@(posedge sys_clk) disable iff (!arst_n)
		!strapsValid |=> intLine_n == `WK_INT_IDLE;
	endproperty
	a_refuse_int: assert property (p_refuse_int) // [R08]
		else $error("interrupt line driven before capture");

	property p_refuse_hit;
		@(posedge sys_clk) disable iff (!arst_n)
		!strapsValid |=> !wakeupHit;
	endproperty
	a_refuse_hit: assert property (p_refuse_hit) // [R10]
		else $error("port hit before capture");

	property p_int_idle;
		@(posedge sys_clk) disable iff (!arst_n)
		!intRequest |=> intLine_n == `WK_INT_IDLE;
	endproperty
	a_int_idle: assert property (p_int_idle) // [R08]
		else $error("interrupt line low without request");

	property p_hit8;
		@(posedge sys_clk) disable iff (!arst_n)
		(strapsValid && ioAccess && !portWide &&
		 ioPortAddr[7:0] == wakeupPort[7:0]) |=> wakeupHit;
	endproperty
	a_hit8: assert property (p_hit8) // [R04] [R10]
		else $error("narrow port match missed");

	property p_miss;
		@(posedge sys_clk) disable iff (!arst_n)
		(strapsValid && ioAccess && portWide &&
		 ioPortAddr != wakeupPort) |=> !wakeupHit;
	endproperty
	a_miss: assert property (p_miss) // [R10]
		else $error("hit on a foreign wide port");

	property p_memwide_on;
		@(posedge sys_clk) disable iff (!arst_n)
		(strapsValid && busWide && memWideCapable) |=> memXferWide;
	endproperty
	a_memwide_on: assert property (p_memwide_on) // [R07]
		else $error("wide transfer not used");

	property p_port16;
		@(posedge sys_clk) disable iff (!arst_n)
		(strapsValid && portWide) |-> wakeupPort == wakeValue;
	endproperty
	a_port16: assert property (p_port16) // [R04] [R05]
		else $error("wide port not the full value");

	property p_frozen_addr;
		@(posedge sys_clk) disable iff (!arst_n)
		$past(strapsValid) && strapsValid |->
			$stable(wakeupAddr24) && $stable(portWide);
	endproperty
	a_frozen_addr: assert property (p_frozen_addr) // [R11]
		else $error("address or port width changed in operation");

	// Reset exit, five settle cycles, capture, then valid one edge later
	sequence s_released;
		$rose(arst_n);
	endsequence

	sequence s_settling;
		!strapsValid [*7];
	endsequence

	sequence s_held;
		strapsValid ##1 strapsValid;
	endsequence

	property p_capture_walk;
		@(posedge sys_clk) disable iff (!arst_n)
		s_released |-> s_settling ##1 s_held;
	endproperty
	a_capture_walk: assert property (p_capture_walk) // [R11]
		else $error("strap capture off its schedule");
endmodule

// ---- dv/host_io_model.sv ----
// Host processor model: issues I/O cycles on the wake-up port bus.
// Assumes one sys_clk domain shared with the decoder.
`timescale 1ns/1ps

module host_io_model (
	input  wire logic        sys_clk,
	output logic             ioAccess,
	output logic [15:0]      ioPortAddr
);
	initial begin
		ioAccess   = 1'b0;
		ioPortAddr = 16'h0000;
	end

	// Released address shows the inverse so a stale value cannot match
	task automatic access(input logic [15:0] port);
		@(posedge sys_clk);
		ioAccess   <= 1'b1;
		ioPortAddr <= port;
		@(posedge sys_clk);
		ioAccess   <= 1'b0;
		ioPortAddr <= ~port;
	endtask
endmodule

// ---- dv/test_host_wakeup_strap_decoder.sv ----
// Self-checking bench for the strap decoder, one strap set per reset.
// Assumes the decoder captures straps once after each reset release.
`timescale 1ns/1ps

module test_host_wakeup_strap_decoder;
	logic        sys_clk, arst_n, topPage, intReq, memCap;
	logic [7:0]  hiStraps;
	logic [9:0]  loStraps;
	logic [2:0]  intSel;
	logic        ioAccess, strapsValid, portWide, busWide, memXferWide;
	logic        wakeupHit;
	logic [15:0] ioPortAddr, wakeupPort, val;
	logic [19:0] wakeupAddr;
	logic [23:0] wakeupAddr24;
	logic [7:0]  intLine_n;
	int          n_mismatch, tests_run, cycles, hits;

	host_wakeup_strap_decoder dut_u (.sys_clk(sys_clk), .arst_n(arst_n),
		.wakeupHighByteStraps(hiStraps), .wakeupLowByteAndWidthStraps(loStraps),
		.topPageSelectStrap(topPage), .interruptLineSelectStrap(intSel),
		.intRequest(intReq), .memWideCapable(memCap), .ioAccess(ioAccess),
		.ioPortAddr(ioPortAddr), .strapsValid(strapsValid),
		.wakeupAddr(wakeupAddr), .wakeupAddr24(wakeupAddr24),
		.wakeupPort(wakeupPort), .portWide(portWide), .busWide(busWide),
		.memXferWide(memXferWide), .wakeupHit(wakeupHit),
		.intLine_n(intLine_n));
	host_io_model host_u (.sys_clk(sys_clk), .ioAccess(ioAccess),
		.ioPortAddr(ioPortAddr));

	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	task automatic chk(input string what, input logic [23:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 6000) begin
			n_mismatch++;
			results();
		end
	end

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	// Straps set before reset, then captured fields compared
	task automatic t_straps(input int i);
		int k;
		@(posedge sys_clk);
		val      = 16'hA5C3 ^ (16'h1357 * i[15:0]);
		hiStraps <= val[15:8];
		loStraps <= {i[1], i[0], val[7:0]};
		topPage  <= i[2];
		intSel   <= i[2:0];
		arst_n   <= 1'b0;
		repeat (4) @(posedge sys_clk);
		arst_n   <= 1'b1;
		for (k = 0; k < 20 && strapsValid !== 1'b1; k++)
			tick(1);
		chk("strapsValid", {23'h0, strapsValid}, 24'h000001);
		chk("validWithin8", 24'(k <= 8), 24'h000001);
		tick(2);
		chk("wakeupAddr", {4'h0, wakeupAddr}, {4'h0, val, 4'h0});
		chk("wakeupAddr24", wakeupAddr24, {i[2] ? 4'hF : 4'h0, val, 4'h0});
		chk("wakeupPort", {8'h0, wakeupPort},
			{8'h0, i[0] ? val[15:8] : 8'h00, val[7:0]});
		chk("portWide", {23'h0, portWide}, {23'h0, i[0]});
		chk("busWide", {23'h0, busWide}, {23'h0, i[1]});
		@(posedge sys_clk);
		hiStraps <= ~val[15:8];
		loStraps <= ~loStraps;
		topPage  <= ~topPage;
		tick(4);
		chk("heldAddr", {4'h0, wakeupAddr}, {4'h0, val, 4'h0});
		$display("test straps %0d done", i);
	endtask

	task automatic t_mem(input int i);
		@(posedge sys_clk);
		memCap <= 1'b1;
		tick(3);
		chk("memXferWide hi", {23'h0, memXferWide}, {23'h0, i[1]});
		@(posedge sys_clk);
		memCap <= 1'b0;
		tick(3);
		chk("memXferWide lo", {23'h0, memXferWide}, 24'h000000);
		$display("test mem width %0d done", i);
	endtask

	// Counts hit pulses seen in the three cycles after one access
	task automatic ioTry(input logic [15:0] port, input logic [23:0] exp);
		host_u.access(port);
		#1;
		hits = int'(wakeupHit === 1'b1);
		repeat (2) begin
			tick(1);
			hits += int'(wakeupHit === 1'b1);
		end
		chk("wakeupHit count", hits[23:0], exp);
	endtask

	task automatic t_io(input int i);
		ioTry(val, 24'h000001);
		ioTry({~val[15:8], val[7:0]}, i[0] ? 24'h0 : 24'h1);
		ioTry({val[15:8], ~val[7:0]}, 24'h000000);
		$display("test io port %0d done", i);
	endtask

	task automatic t_int(input int i);
		@(posedge sys_clk);
		intReq <= 1'b1;
		tick(3);
		chk("intLine_n on", {16'h0, intLine_n},
			{16'h0, ~(8'h01 << i[2:0])});
		@(posedge sys_clk);
		intReq <= 1'b0;
		tick(3);
		chk("intLine_n off", {16'h0, intLine_n}, 24'h0000FF);
		$display("test interrupt %0d done", i);
	endtask

	initial begin
		arst_n     = 1'b0;
		hiStraps   = 8'h00;
		loStraps   = 10'h000;
		topPage    = 1'b0;
		intSel     = 3'h0;
		intReq     = 1'b0;
		memCap     = 1'b0;
		n_mismatch = 0;
		tests_run  = 0;
		for (int i = 0; i < 8; i++) begin
			t_straps(i);
			t_mem(i);
			t_io(i);
			t_int(i);
		end
		results();
	end
endmodule
